// File: verilog/serdes_rx_link_setup.sv
// What this block does
// - Two-link mode keeps a per-link register copy chosen by link_select.
// - Interface power and idle lane mask are shared by both links.
// - Writing zero to interface power powers up the receive interface.
// - Count fields (lanes, octets, frames, converters, resolution, sample bits, samples) hold value minus one; device adds one.
// - Lane count minus one in bits 4:0, scrambling enable in bit 7.
// - Clock config bit 5 selects half rate, bit 1 oversampled recovery.
// - Divider bits 1:0 must match recovery mode; host sets bit 2.
// - Equalizer mode in bits 7:6; low six bits keep their default.
`timescale 1ns/1ps
module serdes_rx_link_setup
  import rx_link_setup_pkg::*;
#(
  parameter int LOCK_COUNT = LOCK_CYCLES
) (
  input  wire logic                       clk_sys,
  input  wire logic                       reset_n,
  input  wire logic                       spi_csb_n,
  input  wire logic                       spi_sclk,
  input  wire logic                       spi_sdi,
  output logic                            spi_sdo_out,
  output logic                            spi_sdo_oe_n,
  output rx_link_setup_pkg::link_params_t link0_params,
  output rx_link_setup_pkg::link_params_t link1_params,
  output rx_link_setup_pkg::phy_config_t  phy_config,
  output logic                            two_link_mode,
  output logic                            link_select,
  output logic                            sum_method
);

  // ==========================================================
  // Serial control port
  // ==========================================================
  spi_req_t   req;
  logic [7:0] rd_data;

  spi_port u_spi_port (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .csb_n    (spi_csb_n),
    .sclk     (spi_sclk),
    .sdi      (spi_sdi),
    .rdata    (rd_data),
    .req      (req),
    .sdo_out  (spi_sdo_out),
    .sdo_oe_n (spi_sdo_oe_n)
  );

  // ==========================================================
  // Register storage
  // ==========================================================
  logic [7:0] common_reg  [NUM_COMMON];
  logic [7:0] common_next [NUM_COMMON];
  logic [7:0] link_reg    [NUM_LINKS][NUM_PER_LINK];
  logic [7:0] link_next   [NUM_LINKS][NUM_PER_LINK];
  int         common_idx;
  int         link_idx;
  logic       page;
  logic       pll_locked;

  // One decode serves writes and reads; the port never does both at once
  assign common_idx = common_index(req.addr);
  assign link_idx   = link_index(req.addr);

  // Page follows link_select only in two-link mode, else always link 0
  assign page = common_reg[C_LINK_CONTROL][TWO_LINK_BIT] &
                common_reg[C_LINK_CONTROL][LINK_SEL_BIT];

  // Write path; unmapped and status addresses drop the write
  always_comb begin
    common_next = common_reg;
    link_next   = link_reg;
    if (req.wr) begin
      if (common_idx >= 0) begin
        common_next[common_idx] = req.wdata;
      end else if (link_idx >= 0) begin
        link_next[page][link_idx] = req.wdata;
      end
    end
  end

  // Reset values are constants; the link copies clear to zero
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_COMMON; i++) begin
        common_reg[i] <= COMMON_RESET[i];
      end
      for (int l = 0; l < NUM_LINKS; l++) begin
        for (int i = 0; i < NUM_PER_LINK; i++) begin
          link_reg[l][i] <= LINK_RESET;
        end
      end
    end else begin
      common_reg <= common_next;
      link_reg   <= link_next;
    end
  end

  // ==========================================================
  // Readback
  // ==========================================================
  // Status is read-only; the selected link's copy is what reads back
  always_comb begin
    rd_data = READ_UNMAPPED;
    if (req.addr == ADDR_PLL_STATUS) begin
      rd_data = 8'h00;
      rd_data[LOCK_BIT] = pll_locked;
    end else if (common_idx >= 0) begin
      rd_data = common_reg[common_idx];
    end else if (link_idx >= 0) begin
      rd_data = link_reg[page][link_idx];
    end
  end

  // ==========================================================
  // Receiver PLL and recovery control
  // ==========================================================
  logic powered;
  logic pll_enable;
  logic recovery_on;

  // Only an exact zero powers up; any other code keeps it down
  assign powered = (common_reg[C_IF_POWER] == POWER_UP_CODE);

  // PLL only locks while powered and enabled
  assign pll_enable = powered &
                      common_reg[C_PLL_ENABLE][ENABLE_BIT];

  // Held in reset until released, and useless before the PLL locks
  assign recovery_on = powered & pll_locked &
                       common_reg[C_RECOVERY_RESET][ENABLE_BIT];

  rx_pll_lock #(
    .LOCK_COUNT (LOCK_COUNT)
  ) u_rx_pll_lock (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .enable  (pll_enable),
    .locked  (pll_locked)
  );

  // ==========================================================
  // Link parameter decode
  // ==========================================================
  // Stored count fields are n-1; the datapath sees n; ids, masks and flags pass as stored
  function automatic link_params_t build_link(
    input logic [7:0] r [NUM_PER_LINK]
  );
    link_params_t p;
    logic [8:0]   w;
    p = '0;
    w = plus_one({3'h0, r[L_SCRAMBLE_LANES][4:0]});
    p.lanes = w[5:0];
    p.scramble_en = r[L_SCRAMBLE_LANES][SCRAMBLE_BIT];
    p.octets = plus_one(r[L_OCTETS]);
    p.frames = plus_one(r[L_FRAMES]);
    p.converters = plus_one(r[L_CONVERTERS]);
    p.resolution = plus_one(r[L_RESOLUTION]);
    w = plus_one({3'h0, r[L_SUBCLASS_BITS][4:0]});
    p.sample_bits = w[5:0];
    w = plus_one({3'h0, r[L_VERSION_SAMPLES][4:0]});
    p.samples = w[5:0];
    p.subclass = r[L_SUBCLASS_BITS][SUBCLASS_BIT];
    p.link_standard_version = r[L_VERSION_SAMPLES][VERSION_BIT];
    p.high_density = r[L_DENSITY][DENSITY_BIT];
    p.device_id = r[L_DEVICE_ID];
    p.bank_id = r[L_BANK_ID];
    p.lane_id = r[L_LANE_ID];
    p.first_lane_sum = r[L_LANE_SUM];
    p.deskew_lanes = r[L_DESKEW];
    p.lane_enable = r[L_LANE_ENABLE];
    return p;
  endfunction

  // ==========================================================
  // Physical layer decode
  // ==========================================================
  function automatic phy_config_t build_phy(
    input logic [7:0] clk_cfg,
    input logic [7:0] divider,
    input logic [7:0] equalizer,
    input logic [7:0] idle_mask
  );
    phy_config_t c;
    c = '0;
    c.half_rate = clk_cfg[HALF_RATE_BIT];
    c.oversampled_recovery = clk_cfg[OVERSAMPLE_BIT];
    c.pll_code = clk_cfg[PLL_CODE_LSB +: 3];
    c.recovery_divider = divider[1:0];
    c.equalizer_setting = equalizer[EQ_LSB +: 2];
    c.idle_lane_mask = idle_mask;
    return c;
  endfunction

  // ==========================================================
  // Output registers
  // ==========================================================
  link_params_t link0_reg, link0_next;
  link_params_t link1_reg, link1_next;
  phy_config_t  phy_reg, phy_next;
  logic         two_link_reg, two_link_next;
  logic         select_reg, select_next;
  logic         sum_reg, sum_next;

  // Settled one cycle after the write so the datapath sees no glitches
  always_comb begin
    link0_next = build_link(link_reg[0]);
    link1_next = build_link(link_reg[1]);
    phy_next   = build_phy(common_reg[C_CLOCK_CONFIG],
                           common_reg[C_DIVIDER],
                           common_reg[C_EQUALIZER],
                           common_reg[C_IDLE_LANES]);
    phy_next.powered         = powered;
    phy_next.pll_enabled     = pll_enable;
    phy_next.pll_locked      = pll_locked;
    phy_next.recovery_active = recovery_on;
    two_link_next = common_reg[C_LINK_CONTROL][TWO_LINK_BIT];
    select_next   = common_reg[C_LINK_CONTROL][LINK_SEL_BIT];
    sum_next      = common_reg[C_LINK_CONTROL][SUM_METHOD_BIT];
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      link0_reg    <= '0;
      link1_reg    <= '0;
      phy_reg      <= '0;
      two_link_reg <= 1'b0;
      select_reg   <= 1'b0;
      sum_reg      <= 1'b0;
    end else begin
      link0_reg    <= link0_next;
      link1_reg    <= link1_next;
      phy_reg      <= phy_next;
      two_link_reg <= two_link_next;
      select_reg   <= select_next;
      sum_reg      <= sum_next;
    end
  end

  assign link0_params  = link0_reg;
  assign link1_params  = link1_reg;
  assign phy_config    = phy_reg;
  assign two_link_mode = two_link_reg;
  assign link_select   = select_reg;
  assign sum_method    = sum_reg;

endmodule

// File: verilog/rx_link_setup_pkg.sv
package rx_link_setup_pkg;

  // ==========================================================
  // Geometry of the serial control port and register space
  // ==========================================================
  localparam int ADDR_W         = 15;
  localparam int SPI_INSTR_BITS = 16;
  localparam int SPI_FRAME_BITS = 24;
  localparam int NUM_COMMON     = 29;
  localparam int NUM_PER_LINK   = 16;
  localparam int NUM_LINKS      = 2;

  // ==========================================================
  // Register slots, common to both links
  // ==========================================================
  typedef enum int {
    C_IF_POWER, C_IDLE_LANES, C_RECOVERY_RESET, C_CLOCK_CONFIG,
    C_EQUALIZER, C_PLL_ENABLE, C_FILTER_A, C_FILTER_B, C_FILTER_C,
    C_PUMP_A, C_DIVIDER, C_REGULATOR, C_CONFIG_A, C_VARACTOR_A,
    C_PUMP_B, C_OSC_A, C_OSC_B, C_CONFIG_B, C_VARACTOR_B, C_PUMP_C,
    C_VARACTOR_C, C_VARACTOR_D, C_AUTOTUNE_A, C_TERM_A_LOW,
    C_TERM_A_HIGH, C_AUTOTUNE_B, C_TERM_B_LOW, C_TERM_B_HIGH,
    C_LINK_CONTROL
  } common_slot_t;

  // Offsets in the same order as the slots above
  localparam logic [14:0] COMMON_ADDR [NUM_COMMON] = '{
    15'h200, 15'h201, 15'h206, 15'h230, 15'h268, 15'h280, 15'h284,
    15'h285, 15'h286, 15'h287, 15'h289, 15'h28a, 15'h28b, 15'h290,
    15'h294, 15'h296, 15'h297, 15'h299, 15'h29a, 15'h29c, 15'h29f,
    15'h2a0, 15'h2a7, 15'h2aa, 15'h2ab, 15'h2ae, 15'h2b1, 15'h2b2,
    15'h300};

  // Interface powered down, recovery held, default PLL and EQ codes
  localparam logic [7:0] COMMON_RESET [NUM_COMMON] = '{
    8'hff, 8'h00, 8'h00, 8'h08, 8'h22, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00};

  // ==========================================================
  // Register slots kept once per link
  // ==========================================================
  typedef enum int {
    L_PORT_CONFIG, L_DEVICE_ID, L_BANK_ID, L_LANE_ID, L_SCRAMBLE_LANES,
    L_OCTETS, L_FRAMES, L_CONVERTERS, L_RESOLUTION, L_SUBCLASS_BITS,
    L_VERSION_SAMPLES, L_DENSITY, L_LANE_SUM, L_DESKEW, L_FRAME_OCTETS,
    L_LANE_ENABLE
  } link_slot_t;

  localparam logic [14:0] LINK_ADDR [NUM_PER_LINK] = '{
    15'h314, 15'h450, 15'h451, 15'h452, 15'h453, 15'h454, 15'h455,
    15'h456, 15'h457, 15'h458, 15'h459, 15'h45a, 15'h45d, 15'h46c,
    15'h476, 15'h47d};

  localparam logic [7:0]  LINK_RESET      = 8'h00;
  localparam logic [14:0] ADDR_PLL_STATUS = 15'h281;
  localparam logic [7:0]  READ_UNMAPPED   = 8'h00;
  localparam logic [7:0]  POWER_UP_CODE   = 8'h00;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int SUM_METHOD_BIT = 6;
  localparam int TWO_LINK_BIT   = 3;
  localparam int LINK_SEL_BIT   = 2;
  localparam int SCRAMBLE_BIT   = 7;
  localparam int SUBCLASS_BIT   = 5;
  localparam int VERSION_BIT    = 5;
  localparam int DENSITY_BIT    = 7;
  localparam int HALF_RATE_BIT  = 5;
  localparam int OVERSAMPLE_BIT = 1;
  localparam int PLL_CODE_LSB   = 2;
  localparam int EQ_LSB         = 6;
  localparam int ENABLE_BIT     = 0;
  localparam int LOCK_BIT       = 0;

  // ==========================================================
  // Timing of the receiver PLL lock
  // ==========================================================
  localparam int CLK_PERIOD_NS = 20;
  localparam int LOCK_TIME_NS  = 20000;
  localparam int LOCK_CYCLES   =
    (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Carriers
  // ==========================================================
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [14:0] addr;
    logic [7:0]  wdata;
  } spi_req_t;

  typedef struct packed {
    logic [5:0] lanes;
    logic [8:0] octets;
    logic [8:0] frames;
    logic [8:0] converters;
    logic [8:0] resolution;
    logic [5:0] sample_bits;
    logic [5:0] samples;
    logic       scramble_en;
    logic       subclass;
    logic       link_standard_version;
    logic       high_density;
    logic [7:0] device_id;
    logic [7:0] bank_id;
    logic [7:0] lane_id;
    logic [7:0] first_lane_sum;
    logic [7:0] deskew_lanes;
    logic [7:0] lane_enable;
  } link_params_t;

  typedef struct packed {
    logic       powered;
    logic [7:0] idle_lane_mask;
    logic       half_rate;
    logic       oversampled_recovery;
    logic [2:0] pll_code;
    logic [1:0] recovery_divider;
    logic [1:0] equalizer_setting;
    logic       recovery_active;
    logic       pll_enabled;
    logic       pll_locked;
  } phy_config_t;

  // Stored value n-1 seen by the datapath as n
  function automatic logic [8:0] plus_one(input logic [7:0] v);
    return {1'b0, v} + 9'h001;
  endfunction

  function automatic int common_index(input logic [14:0] a);
    common_index = -1;
    for (int i = 0; i < NUM_COMMON; i++) begin
      if (COMMON_ADDR[i] == a) common_index = i;
    end
  endfunction

  function automatic int link_index(input logic [14:0] a);
    link_index = -1;
    for (int i = 0; i < NUM_PER_LINK; i++) begin
      if (LINK_ADDR[i] == a) link_index = i;
    end
  endfunction

endpackage

// File: verilog/spi_port.sv
`timescale 1ns/1ps
module spi_port
  import rx_link_setup_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  input  wire logic                   csb_n,
  input  wire logic                   sclk,
  input  wire logic                   sdi,
  input  wire logic [7:0]             rdata,
  output rx_link_setup_pkg::spi_req_t req,
  output logic                        sdo_out,
  output logic                        sdo_oe_n
);

  // ==========================================================
  // Serial framing: R/W bit, 15 address bits, 8 data bits
  // ==========================================================
  logic       sclk_reg, sclk_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [23:0] shift_reg, shift_next;
  logic [7:0] out_reg, out_next;
  logic       reading_reg, reading_next;
  logic       load_reg, load_next;
  logic       oe_n_reg, oe_n_next;
  spi_req_t   req_reg, req_next;
  logic       rise, fall;

  // Edges of sclk, only while selected
  assign rise = sclk & ~sclk_reg & ~csb_n;
  assign fall = ~sclk & sclk_reg & ~csb_n;

  // Next state of the shifter; bits beyond one frame are ignored
  always_comb begin
    sclk_next    = sclk;
    cnt_next     = cnt_reg;
    shift_next   = shift_reg;
    out_next     = out_reg;
    reading_next = reading_reg;
    load_next    = 1'b0;
    oe_n_next    = oe_n_reg;
    req_next     = '{wr: 1'b0, rd: 1'b0, addr: req_reg.addr,
                     wdata: req_reg.wdata};
    if (load_reg) out_next = rdata;
    if (csb_n) begin
      cnt_next     = 5'h00;
      reading_next = 1'b0;
      oe_n_next    = 1'b1;
    end else if (rise && cnt_reg < 5'(SPI_FRAME_BITS)) begin
      shift_next = {shift_reg[22:0], sdi};
      cnt_next   = cnt_reg + 5'h01;
      if (cnt_reg == 5'(SPI_INSTR_BITS - 1)) begin
        req_next.addr = {shift_reg[13:0], sdi};
        reading_next  = shift_reg[14];
        req_next.rd   = shift_reg[14];
        load_next     = shift_reg[14];
      end
      if (cnt_reg == 5'(SPI_FRAME_BITS - 1) && !reading_reg) begin
        req_next.wr    = 1'b1;
        req_next.wdata = {shift_reg[6:0], sdi};
      end
    end else if (fall && reading_reg) begin
      // First falling edge presents bit 7, later ones shift
      if (!oe_n_reg) out_next = {out_reg[6:0], 1'b0};
      oe_n_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sclk_reg    <= 1'b0;
      cnt_reg     <= 5'h00;
      shift_reg   <= 24'h000000;
      out_reg     <= 8'h00;
      reading_reg <= 1'b0;
      load_reg    <= 1'b0;
      oe_n_reg    <= 1'b1;
      req_reg     <= '0;
    end else begin
      sclk_reg    <= sclk_next;
      cnt_reg     <= cnt_next;
      shift_reg   <= shift_next;
      out_reg     <= out_next;
      reading_reg <= reading_next;
      load_reg    <= load_next;
      oe_n_reg    <= oe_n_next;
      req_reg     <= req_next;
    end
  end

  assign req      = req_reg;
  assign sdo_out  = out_reg[7];
  assign sdo_oe_n = oe_n_reg;

endmodule

// File: verilog/rx_pll_lock.sv
`timescale 1ns/1ps
module rx_pll_lock #(
  parameter int LOCK_COUNT = rx_link_setup_pkg::LOCK_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic enable,
  output logic      locked
);

  if (LOCK_COUNT < 1 || LOCK_COUNT > 65535) begin : g_bad_count
    $error("LOCK_COUNT out of range");
  end

  // ==========================================================
  // Lock timer, restarted whenever the PLL is disabled
  // ==========================================================
  logic [15:0] count_reg, count_next;
  logic        locked_reg, locked_next;

  always_comb begin
    count_next  = count_reg;
    locked_next = locked_reg;
    if (!enable) begin
      count_next  = 16'h0000;
      locked_next = 1'b0;
    end else if (!locked_reg) begin
      count_next  = count_reg + 16'h0001;
      locked_next = (count_reg == 16'(LOCK_COUNT - 1));
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_reg  <= 16'h0000;
      locked_reg <= 1'b0;
    end else begin
      count_reg  <= count_next;
      locked_reg <= locked_next;
    end
  end

  assign locked = locked_reg;

endmodule

// File: tb/spi_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host side of the serial control port
// ==========================================================
module spi_host_model #(
  parameter int HALF = 4
) (
  input  wire logic clk_sys,
  output logic      csb_n,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo_out,
  input  wire logic sdo_oe_n
);
  // Idle: deselected, clock parked low
  initial begin
    csb_n = 1'b1;
    sclk  = 1'b0;
    sdi   = 1'b0;
  end

  // One byte per frame; phases never shorter than HALF cycles
  task automatic xfer(input logic rw, input logic [14:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    logic [23:0] f;
    f = {rw, a, d};
    q = 8'h00;
    @(posedge clk_sys) csb_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      @(posedge clk_sys) sdi <= f[i];
      sclk <= 1'b0;
      repeat (HALF) @(posedge clk_sys);
      sclk <= 1'b1;
      // Undriven line reads unknown, so a late enable shows up
      if (i < 8) q = {q[6:0], sdo_oe_n ? 1'bx : sdo_out};
      repeat (HALF - 1) @(posedge clk_sys);
    end
    @(posedge clk_sys) sclk <= 1'b0;
    repeat (HALF) @(posedge clk_sys);
    csb_n <= 1'b1;
    sdi   <= ~sdi;
    repeat (3) @(posedge clk_sys);
  endtask
endmodule

// File: tb/serdes_rx_link_setup_props.sv
`timescale 1ns/1ps
// ==========================================================
// Port checks for the link setup register bank
// ==========================================================
module serdes_rx_link_setup_props
  import rx_link_setup_pkg::*;
#(
  parameter int LOCK_COUNT = 4
) (
  input wire logic                       clk_sys,
  input wire logic                       reset_n,
  input wire logic                       spi_csb_n,
  input wire logic                       spi_sclk,
  input wire logic                       spi_sdi,
  input wire logic                       spi_sdo_out,
  input wire logic                       spi_sdo_oe_n,
  input wire rx_link_setup_pkg::link_params_t link0_params,
  input wire rx_link_setup_pkg::link_params_t link1_params,
  input wire rx_link_setup_pkg::phy_config_t  phy_config,
  input wire logic                       two_link_mode,
  input wire logic                       link_select,
  input wire logic                       sum_method
);
  logic [31:0] idle_reg, idle_next, on_reg, on_next;
  logic [1:0]  age_reg, age_next;

  // Deselect time, enabled time, age since reset (saturating)
  always_comb begin
    idle_next = spi_csb_n ? idle_reg + 32'h1 : 32'h0;
    on_next   = phy_config.pll_enabled ? on_reg + 32'h1 : 32'h0;
    age_next  = (age_reg == 2'd3) ? 2'd3 : age_reg + 2'd1;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      idle_reg <= 32'h0;
      on_reg   <= 32'h0;
      age_reg  <= 2'd0;
    end else begin
      idle_reg <= idle_next;
      on_reg   <= on_next;
      age_reg  <= age_next;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  chk_sdo_released: assert property (
    spi_csb_n [*3] |-> spi_sdo_oe_n) else $error("sdo driven when idle");
  chk_params_hold: assert property (
    idle_reg >= 32'd5 |-> $stable(link0_params) && $stable(link1_params)
    && $stable(two_link_mode)) else $error("params moved while idle");
  chk_page_one_hold: assert property (
    (!two_link_mode) [*4] |-> $stable(link1_params))
    else $error("link 1 copy written in single mode");
  chk_recovery_gate: assert property (
    phy_config.recovery_active |-> phy_config.powered
    && phy_config.pll_locked) else $error("recovery active too soon");
  chk_lock_early: assert property (
    phy_config.pll_locked |-> on_reg >= LOCK_COUNT)
    else $error("lock before count");
  chk_lock_late: assert property (
    on_reg == LOCK_COUNT + 3 |-> phy_config.pll_locked)
    else $error("lock missing");
  chk_unlock_fast: assert property (
    !phy_config.pll_enabled |=> !phy_config.pll_locked)
    else $error("lock held after disable");
  chk_lane_range: assert property (
    age_reg == 2'd3 |-> link0_params.lanes inside {[1:32]}
    && link1_params.lanes inside {[1:32]}) else $error("lane count");
  chk_minus_one: assert property (
    age_reg == 2'd3 |-> link0_params.octets != 9'h0
    && link0_params.samples != 6'h0) else $error("zero field");

  // Main scenarios reached
  cover property (phy_config.pll_locked && phy_config.recovery_active);
  cover property (two_link_mode && link_select);
  cover property (!spi_sdo_oe_n);
endmodule

bind serdes_rx_link_setup serdes_rx_link_setup_props #(
  .LOCK_COUNT(LOCK_COUNT)
) serdes_rx_link_setup_props_inst (
  .clk_sys(clk_sys), .reset_n(reset_n), .spi_csb_n(spi_csb_n),
  .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo_out(spi_sdo_out),
  .spi_sdo_oe_n(spi_sdo_oe_n), .link0_params(link0_params),
  .link1_params(link1_params), .phy_config(phy_config),
  .two_link_mode(two_link_mode), .link_select(link_select),
  .sum_method(sum_method));

// File: tb/tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// Bench for the link setup register bank
// ==========================================================
module tb_top;
  import rx_link_setup_pkg::*;
  localparam int LK = 4;
  logic         clk_sys = 1'b0;
  logic         reset_n = 1'b0;
  logic         csb_n, sclk, sdi, sdo_out, sdo_oe_n;
  logic         two_link_mode, link_select, sum_method;
  link_params_t link0_params, link1_params;
  phy_config_t  phy_config;
  logic [7:0]   m [int];
  logic [7:0]   q;
  int           bad_count = 0;
  int           num_checks = 0;
  always #10 clk_sys = ~clk_sys;

  // Short lock count keeps each write's settle wait small
  serdes_rx_link_setup #(.LOCK_COUNT(LK)) serdes_rx_link_setup_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .spi_csb_n(csb_n),
    .spi_sclk(sclk), .spi_sdi(sdi), .spi_sdo_out(sdo_out),
    .spi_sdo_oe_n(sdo_oe_n), .link0_params(link0_params),
    .link1_params(link1_params), .phy_config(phy_config),
    .two_link_mode(two_link_mode), .link_select(link_select),
    .sum_method(sum_method));
  spi_host_model spi_host_model_inst (
    .clk_sys(clk_sys), .csb_n(csb_n), .sclk(sclk), .sdi(sdi),
    .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n));

  task chk(input logic [127:0] seen, input logic [127:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Per-link slots live at a second page
  function automatic int k(input logic [14:0] a);
    return m.exists(a + 'h8000) ? a + (m['h300][3] & m['h300][2]) * 'h8000 : a;
  endfunction

  function automatic link_params_t el(input int p);
    link_params_t e;
    logic [7:0]   b [16];
    for (int i = 0; i < 16; i++) b[i] = m[LINK_ADDR[i] + p * 'h8000];
    e = '0;
    e.lanes = b[L_SCRAMBLE_LANES][4:0] + 6'h1;
    e.scramble_en = b[L_SCRAMBLE_LANES][7];
    e.octets = b[L_OCTETS] + 9'h1;
    e.frames = b[L_FRAMES] + 9'h1;
    e.converters = b[L_CONVERTERS] + 9'h1;
    e.resolution = b[L_RESOLUTION] + 9'h1;
    e.sample_bits = b[L_SUBCLASS_BITS][4:0] + 6'h1;
    e.samples = b[L_VERSION_SAMPLES][4:0] + 6'h1;
    e.subclass = b[L_SUBCLASS_BITS][5];
    e.link_standard_version = b[L_VERSION_SAMPLES][5];
    e.high_density = b[L_DENSITY][7];
    e.device_id = b[L_DEVICE_ID];
    e.bank_id = b[L_BANK_ID];
    e.lane_id = b[L_LANE_ID];
    e.first_lane_sum = b[L_LANE_SUM];
    e.deskew_lanes = b[L_DESKEW];
    e.lane_enable = b[L_LANE_ENABLE];
    return e;
  endfunction

  // Every decoded output against the model
  task dec;
    phy_config_t e;
    e = '0;
    e.powered = m['h200] == 8'h00;
    e.idle_lane_mask = m['h201];
    e.half_rate = m['h230][5];
    e.oversampled_recovery = m['h230][1];
    e.pll_code = m['h230][4:2];
    e.recovery_divider = m['h289][1:0];
    e.equalizer_setting = m['h268][7:6];
    e.pll_enabled = e.powered & m['h280][0];
    e.pll_locked = e.pll_enabled;
    e.recovery_active = e.pll_locked & m['h206][0];
    chk(phy_config, e);
    chk({two_link_mode, link_select, sum_method},
        {m['h300][3:2], m['h300][6]});
    chk(link0_params, el(0));
    chk(link1_params, el(1));
  endtask

  task wr(input logic [14:0] a, input logic [7:0] d);
    int c;
    c = k(a);
    spi_host_model_inst.xfer(1'b0, a, d, q);
    if (m.exists(c)) m[c] = d;
    repeat (12) @(posedge clk_sys);
    dec;
  endtask

  task rd(input logic [14:0] a);
    int c;
    c = k(a);
    spi_host_model_inst.xfer(1'b1, a, 8'h00, q);
    if (a == 15'h281) chk(q, {7'h0, m['h200] == 8'h00 && m['h280][0]});
    else chk(q, m.exists(c) ? m[c] : 8'h00);
  endtask

  // Main sequence
  initial begin
    static int seq [$] = '{'h20000, 'h2010f, 'h2aab7, 'h2ab87, 'h2b1b7,
      'h2b287, 'h2a701, 'h2ae01, 'h31401, 'h2302a, 'h20600, 'h20601,
      'h28906, 'h28462, 'h285c9, 'h2860e, 'h28712, 'h28a7b, 'h28b00,
      'h29089, 'h29424, 'h29603, 'h2970d, 'h29902, 'h29a8e, 'h29c2a,
      'h29f78, 'h2a006, 'h28001, 'h26862, 'h268e2, 'h268a2, 'h20600,
      'h20601, 'h281ff, 'h20001, 'h20000, 'h28000, 'h28001};
    void'($urandom(38));
    foreach (COMMON_ADDR[i]) m[COMMON_ADDR[i]] = COMMON_RESET[i];
    foreach (LINK_ADDR[i]) begin
      m[LINK_ADDR[i]] = LINK_RESET;
      m[LINK_ADDR[i] + 'h8000] = LINK_RESET;
    end
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    dec;
    foreach (COMMON_ADDR[i]) rd(COMMON_ADDR[i]);
    foreach (LINK_ADDR[i]) rd(LINK_ADDR[i]);
    rd(15'h123);
    // Bring-up order; one entry hits the read-only status
    foreach (seq[i]) wr(seq[i][22:8], seq[i][7:0]);
    rd(15'h281);
    // Both link copies in two-link mode, random, density bits 4:0 kept zero
    for (int p = 0; p < 2; p++) begin
      wr(15'h300, {1'b0, 1'($urandom), 2'b00, 1'b1, p[0], 2'b11});
      foreach (LINK_ADDR[i]) wr(LINK_ADDR[i], 8'($urandom) &
        (i == L_DENSITY ? 8'he0 : 8'hff));
    end
    foreach (LINK_ADDR[i]) rd(LINK_ADDR[i]);
    wr(15'h300, 8'h0b);
    foreach (LINK_ADDR[i]) rd(LINK_ADDR[i]);
    wr(15'h300, 8'h01);
    wr(15'h453, 8'h9f);
    rd(15'h453);
    give_verdict;
  end

  // Hang guard
  initial begin
    repeat (80000) @(posedge clk_sys);
    bad_count++;
    give_verdict;
  end
endmodule
